// >>> src/acs_pkg.sv
// shared constants and types for the converter selection and result block
package acs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam int         ACS_ADDR_W        = 8;
  localparam logic [7:0] ACS_OFF_SELECT    = 8'h00;
  localparam logic [7:0] ACS_OFF_RES_LOW   = 8'h04;
  localparam logic [7:0] ACS_OFF_RES_HIGH  = 8'h08;
  localparam logic [7:0] ACS_OFF_STATUS    = 8'h0c;
  localparam logic [7:0] ACS_OFF_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] ACS_OFF_IRQ_EN    = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // input select register layout
  localparam int         ACS_REFSEL_MSB   = 7;
  localparam int         ACS_REFSEL_LSB   = 6;
  localparam int         ACS_LADJ_BIT     = 5;
  localparam int         ACS_CHSEL_MSB    = 4;
  localparam int         ACS_CHSEL_LSB    = 0;
  localparam logic [7:0] ACS_SELECT_RESET = 8'h00;

  // status, clear and enable share the done and drop bits; busy is in status only
  localparam int         ACS_EVT_W       = 2;
  localparam int         ACS_ST_DONE     = 0;
  localparam int         ACS_ST_DROP     = 1;
  localparam int         ACS_ST_BUSY     = 2;
  localparam logic [1:0] ACS_EVT_RESET   = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // selection codes
  localparam logic [1:0] ACS_REF_EXT     = 2'h0;
  localparam logic [1:0] ACS_REF_SUPPLY  = 2'h1;
  localparam logic [1:0] ACS_REF_RSVD    = 2'h2;
  localparam logic [1:0] ACS_REF_INT     = 2'h3;
  localparam logic [4:0] ACS_CH_BANDGAP  = 5'h1e;
  localparam logic [4:0] ACS_CH_GROUND   = 5'h1f;

  // result scaling and limits
  localparam int         ACS_SE_FULL     = 1024;
  localparam int         ACS_DIFF_FULL   = 512;
  localparam logic [9:0] ACS_SE_MAX      = 10'h3ff;
  localparam logic [9:0] ACS_DIFF_MAX    = 10'h1ff;
  localparam logic [9:0] ACS_DIFF_MIN    = 10'h200;

  localparam logic [1:0] ACS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ACS_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ACS_GAIN_1X   = 3'h1,
    ACS_GAIN_10X  = 3'h2,
    ACS_GAIN_200X = 3'h4
  } acs_gain_e;

  typedef enum logic [3:0] {
    ACS_WS_IDLE = 4'h1,
    ACS_WS_ADDR = 4'h2,
    ACS_WS_DATA = 4'h4,
    ACS_WS_RESP = 4'h8
  } acs_wstate_e;

endpackage

// >>> src/acs_sel_decode.sv
// decodes channel/gain and reference codes into analog switch controls
`timescale 1ns/1ns
module acs_sel_decode
  import acs_pkg::*;
(
  input  wire logic [4:0] chsel,
  input  wire logic [1:0] refsel,
  output logic            single_ended_sel,
  output logic [2:0]      pos_input_sel,
  output logic [1:0]      neg_input_sel,
  output acs_gain_e       gain_sel,
  output logic            bandgap_sel,
  output logic            ground_sel,
  output logic            ref_external_sel,
  output logic            ref_supply_sel,
  output logic            ref_internal_on,
  output logic            ref_reserved_sel
);

  always_comb begin
    single_ended_sel = 1'b0;
    pos_input_sel    = chsel[2:0];
    neg_input_sel    = 2'h0;
    gain_sel         = ACS_GAIN_1X;
    bandgap_sel      = 1'b0;
    ground_sel       = 1'b0;
    unique case (chsel[4:3])
      2'h0: begin
        single_ended_sel = 1'b1; // RQ8
      end
      2'h1: begin
        // pairs alternate 10x and 200x; same-input codes null the offset
        pos_input_sel = {1'b0, chsel[2], chsel[0]}; // RQ9
        neg_input_sel = chsel[2] ? 2'h2 : 2'h0; // RQ9
        gain_sel      = chsel[1] ? ACS_GAIN_200X : ACS_GAIN_10X; // RQ9
      end
      2'h2: begin
        neg_input_sel = 2'h1; // RQ10
      end
      2'h3: begin
        if (chsel == ACS_CH_BANDGAP || chsel == ACS_CH_GROUND) begin
          single_ended_sel = 1'b1; // RQ8
          pos_input_sel    = 3'h0;
          bandgap_sel      = (chsel == ACS_CH_BANDGAP); // RQ8
          ground_sel       = (chsel == ACS_CH_GROUND); // RQ8
        end else begin
          neg_input_sel = 2'h2; // RQ10
        end
      end
    endcase
  end

  // RQ5
  assign ref_external_sel = (refsel == ACS_REF_EXT);
  assign ref_supply_sel   = (refsel == ACS_REF_SUPPLY);
  assign ref_reserved_sel = (refsel == ACS_REF_RSVD);
  assign ref_internal_on  = (refsel == ACS_REF_INT);

endmodule // acs_sel_decode

// >>> src/acs_result_format.sv
// places a 10-bit result into the high and low result bytes
`timescale 1ns/1ns
module acs_result_format (
  input  wire logic [9:0] result,
  input  wire logic       left_adjust,
  output logic [7:0]      result_low_byte,
  output logic [7:0]      result_high_byte
);

  always_comb begin
    if (left_adjust) begin
      result_high_byte = result[9:2]; // RQ12
      result_low_byte  = {result[1:0], 6'h00}; // RQ12
    end else begin
      result_high_byte = {6'h00, result[9:8]}; // RQ12
      result_low_byte  = result[7:0];
    end
  end

endmodule // acs_result_format

// >>> src/acs_top.sv
// converter input selection, result formatting and register slave
//
// Contract
// RQ1: single-ended result is unsigned, clamped 0x000..0x3FF
// RQ2: differential result is two's complement 0x200..0x1FF
// RQ3: differential result msb is the sign
// RQ4: result bytes valid once completion flag set
// RQ5: reference field picks external, supply or internal
// RQ6: selection writes wait for running conversion end
// RQ7: left adjust bit reformats result bytes immediately
// RQ8: codes 0-7 single inputs, bandgap, ground
// RQ9: low differential pairs, 10x/200x gain alternating
// RQ10: input 1 and 2 negative codes, unity gain
// RQ11: eight-bit select register, reset zero, read/write
// RQ12: left adjust puts bits 9:2 in high
// RQ13: low byte read freezes result until high read
// RQ14: differential overrange saturates instead of wrapping
`timescale 1ns/1ns
module acs_top
  import acs_pkg::*;
#(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic [ACS_ADDR_W-1:0] s_axil_awaddr,
  input  wire logic                  s_axil_awvalid,
  output logic                       s_axil_awready,
  input  wire logic [31:0]           s_axil_wdata,
  input  wire logic [3:0]            s_axil_wstrb,
  input  wire logic                  s_axil_wvalid,
  output logic                       s_axil_wready,
  output logic [1:0]                 s_axil_bresp,
  output logic                       s_axil_bvalid,
  input  wire logic                  s_axil_bready,
  input  wire logic [ACS_ADDR_W-1:0] s_axil_araddr,
  input  wire logic                  s_axil_arvalid,
  output logic                       s_axil_arready,
  output logic [31:0]                s_axil_rdata,
  output logic [1:0]                 s_axil_rresp,
  output logic                       s_axil_rvalid,
  input  wire logic                  s_axil_rready,
  input  wire logic                  conv_busy,
  input  wire logic                  conv_done,
  input  wire logic signed [SAMPLE_W-1:0] conv_sample,
  output logic                       single_ended_sel,
  output logic [2:0]                 pos_input_sel,
  output logic [1:0]                 neg_input_sel,
  output acs_gain_e                  gain_sel,
  output logic                       bandgap_sel,
  output logic                       ground_sel,
  output logic                       ref_external_sel,
  output logic                       ref_supply_sel,
  output logic                       ref_internal_on,
  output logic                       ref_reserved_sel,
  output logic                       conversion_complete_flag,
  output logic                       irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0]           input_select;
    logic [1:0]           applied_ref;
    logic [4:0]           applied_ch;
    logic [9:0]           result;
    logic                 lock;
    logic [ACS_EVT_W-1:0] status;
    logic [ACS_EVT_W-1:0] irq_en;
    acs_wstate_e          wstate;
    logic [7:0]           awaddr;
    logic [7:0]           wdata;
    logic                 wstrb0;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [7:0]           rdata;
    logic [1:0]           rresp;
  } acs_top_s;

  localparam acs_top_s ST_RESET = '{
    input_select: ACS_SELECT_RESET,
    status:       ACS_EVT_RESET,
    irq_en:       ACS_EVT_RESET,
    wstate:       ACS_WS_IDLE,
    default:      '0
  };

  localparam logic signed [SAMPLE_W-1:0] SMP_SE_TOP =
    SAMPLE_W'(ACS_SE_FULL - 1);
  localparam logic signed [SAMPLE_W-1:0] SMP_DIFF_TOP =
    SAMPLE_W'(ACS_DIFF_FULL - 1);
  localparam logic signed [SAMPLE_W-1:0] SMP_DIFF_BOT =
    SAMPLE_W'(-ACS_DIFF_FULL);

  acs_top_s st_reg;
  acs_top_s st_next;

  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  logic       commit;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_strb0;
  logic       rd_low;
  logic       rd_high;
  logic       capture;
  logic [9:0] sample_code;
  logic [7:0] fmt_low;
  logic [7:0] fmt_high;
  logic [ACS_EVT_W-1:0] evt;
  logic [ACS_EVT_W-1:0] clr;

  function automatic logic map_hit(input logic [7:0] a);
    map_hit = (a == ACS_OFF_SELECT)    || (a == ACS_OFF_RES_LOW) ||
              (a == ACS_OFF_RES_HIGH)  || (a == ACS_OFF_STATUS) ||
              (a == ACS_OFF_IRQ_CLEAR) || (a == ACS_OFF_IRQ_EN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // submodules

  acs_sel_decode u_decode (
    .chsel            (st_reg.applied_ch),
    .refsel           (st_reg.applied_ref),
    .single_ended_sel (single_ended_sel),
    .pos_input_sel    (pos_input_sel),
    .neg_input_sel    (neg_input_sel),
    .gain_sel         (gain_sel),
    .bandgap_sel      (bandgap_sel),
    .ground_sel       (ground_sel),
    .ref_external_sel (ref_external_sel),
    .ref_supply_sel   (ref_supply_sel),
    .ref_internal_on  (ref_internal_on),
    .ref_reserved_sel (ref_reserved_sel)
  );

  // live bit, not the applied copy: the layout follows it at once
  acs_result_format u_format (
    .result           (st_reg.result),
    .left_adjust      (st_reg.input_select[ACS_LADJ_BIT]), // RQ7
    .result_low_byte  (fmt_low),
    .result_high_byte (fmt_high)
  );

  ////////////////////////////////////////////////////////////////////////////
  // handshakes; gated by ce so no transfer happens while frozen

  assign s_axil_awready = ce && (st_reg.wstate == ACS_WS_IDLE ||
                                 st_reg.wstate == ACS_WS_DATA);
  assign s_axil_wready  = ce && (st_reg.wstate == ACS_WS_IDLE ||
                                 st_reg.wstate == ACS_WS_ADDR);
  assign s_axil_bvalid  = ce && (st_reg.wstate == ACS_WS_RESP);
  assign s_axil_bresp   = st_reg.bresp;
  assign s_axil_arready = ce && !st_reg.rvalid;
  assign s_axil_rvalid  = ce && st_reg.rvalid;
  assign s_axil_rdata   = {24'h000000, st_reg.rdata};
  assign s_axil_rresp   = st_reg.rresp;

  assign aw_hs    = s_axil_awvalid && s_axil_awready;
  assign w_hs     = s_axil_wvalid && s_axil_wready;
  assign ar_hs    = s_axil_arvalid && s_axil_arready;
  assign wr_addr  = aw_hs ? s_axil_awaddr : st_reg.awaddr;
  assign wr_data  = w_hs ? s_axil_wdata[7:0] : st_reg.wdata;
  assign wr_strb0 = w_hs ? s_axil_wstrb[0] : st_reg.wstrb0;

  assign conversion_complete_flag = st_reg.status[ACS_ST_DONE]; // RQ4
  assign irq = |(st_reg.status & st_reg.irq_en);

  ////////////////////////////////////////////////////////////////////////////
  // saturation of the converter's sample into a 10-bit code

  always_comb begin
    if (!single_ended_sel) begin
      if (conv_sample > SMP_DIFF_TOP) begin
        sample_code = ACS_DIFF_MAX; // RQ14
      end else if (conv_sample < SMP_DIFF_BOT) begin
        sample_code = ACS_DIFF_MIN; // RQ14
      end else begin
        sample_code = conv_sample[9:0]; // RQ2 RQ3
      end
    end else begin
      if (conv_sample > SMP_SE_TOP) begin
        sample_code = ACS_SE_MAX; // RQ1
      end else if (conv_sample < 0) begin
        sample_code = 10'h000; // RQ1
      end else begin
        sample_code = conv_sample[9:0]; // RQ1
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;
    commit  = 1'b0;
    rd_low  = 1'b0;
    rd_high = 1'b0;
    clr     = '0;

    if (aw_hs) begin
      st_next.awaddr = s_axil_awaddr;
    end
    if (w_hs) begin
      st_next.wdata  = s_axil_wdata[7:0];
      st_next.wstrb0 = s_axil_wstrb[0];
    end
    unique case (st_reg.wstate)
      ACS_WS_IDLE: begin
        if (aw_hs && w_hs) begin
          commit = 1'b1;
        end else if (aw_hs) begin
          st_next.wstate = ACS_WS_ADDR;
        end else if (w_hs) begin
          st_next.wstate = ACS_WS_DATA;
        end
      end
      ACS_WS_ADDR: begin
        commit = w_hs;
      end
      ACS_WS_DATA: begin
        commit = aw_hs;
      end
      ACS_WS_RESP: begin
        if (s_axil_bready) begin
          st_next.wstate = ACS_WS_IDLE;
        end
      end
      default: begin
        st_next.wstate = ACS_WS_IDLE;
      end
    endcase

    if (commit) begin
      st_next.wstate = ACS_WS_RESP;
      st_next.bresp  = map_hit(wr_addr) ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
      if (wr_strb0) begin
        if (wr_addr == ACS_OFF_SELECT) begin
          st_next.input_select = wr_data; // RQ11
        end
        if (wr_addr == ACS_OFF_IRQ_CLEAR) begin
          clr = wr_data[ACS_EVT_W-1:0];
        end
        if (wr_addr == ACS_OFF_IRQ_EN) begin
          st_next.irq_en = wr_data[ACS_EVT_W-1:0];
        end
      end
    end

    if (ar_hs) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = map_hit(s_axil_araddr) ? ACS_RESP_OKAY
                                              : ACS_RESP_SLVERR;
      st_next.rdata  = 8'h00;
      unique case (s_axil_araddr)
        ACS_OFF_SELECT: begin
          st_next.rdata = st_reg.input_select;
        end
        ACS_OFF_RES_LOW: begin
          st_next.rdata = fmt_low;
          rd_low        = 1'b1;
        end
        ACS_OFF_RES_HIGH: begin
          st_next.rdata = fmt_high;
          rd_high       = 1'b1;
        end
        ACS_OFF_STATUS: begin
          st_next.rdata = {5'h00, conv_busy, st_reg.status};
        end
        ACS_OFF_IRQ_EN: begin
          st_next.rdata = {6'h00, st_reg.irq_en};
        end
        default: begin
          st_next.rdata = 8'h00;
        end
      endcase
    end else if (st_reg.rvalid && s_axil_rready) begin
      st_next.rvalid = 1'b0;
    end

    // a low read in the same cycle as completion still guards old data
    if (rd_low) begin
      st_next.lock = 1'b1; // RQ13
    end else if (rd_high) begin
      st_next.lock = 1'b0; // RQ13
    end
    capture = conv_done && !st_reg.lock && !rd_low; // RQ13
    if (capture) begin
      st_next.result = sample_code; // RQ4
    end

    // a result refused by the lock is lost; software sees it as a drop
    evt = '0;
    evt[ACS_ST_DONE] = capture;
    evt[ACS_ST_DROP] = conv_done && !capture;
    st_next.status = (st_reg.status & ~clr) | evt;

    // idle converter takes the selection at once, busy one at its end
    if (!conv_busy || conv_done) begin
      st_next.applied_ref =
        st_reg.input_select[ACS_REFSEL_MSB:ACS_REFSEL_LSB]; // RQ6
      st_next.applied_ch  =
        st_reg.input_select[ACS_CHSEL_MSB:ACS_CHSEL_LSB]; // RQ6
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= ST_RESET;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  logic [9:0] smp_low;
  logic [6:0] sel_fields;
  assign smp_low    = conv_sample[9:0];
  assign sel_fields = {st_reg.input_select[ACS_REFSEL_MSB:ACS_REFSEL_LSB],
                       st_reg.input_select[ACS_CHSEL_MSB:ACS_CHSEL_LSB]};

  default clocking acs_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_se_code_clamp: assert property ( // RQ1
    ce && capture && single_ended_sel && conv_sample > SMP_SE_TOP
    |=> st_reg.result == ACS_SE_MAX)
    else $error("single-ended overrange not clamped");

  a_se_code_pass: assert property ( // RQ1
    ce && capture && single_ended_sel && conv_sample >= 0 &&
    conv_sample <= SMP_SE_TOP
    |=> st_reg.result == $past(smp_low))
    else $error("single-ended code not passed");

  a_diff_code_pass: assert property ( // RQ2
    ce && capture && !single_ended_sel && conv_sample >= SMP_DIFF_BOT &&
    conv_sample <= SMP_DIFF_TOP
    |=> st_reg.result == $past(smp_low))
    else $error("differential code not passed");

  a_diff_sign_bit: assert property ( // RQ3
    ce && capture && !single_ended_sel
    |=> st_reg.result[9] == $past(conv_sample[SAMPLE_W-1]))
    else $error("differential sign bit wrong");

  a_diff_sat_high: assert property ( // RQ14
    ce && capture && !single_ended_sel && conv_sample > SMP_DIFF_TOP
    |=> st_reg.result == ACS_DIFF_MAX)
    else $error("positive overrange not saturated");

  a_diff_sat_low: assert property ( // RQ14
    ce && capture && !single_ended_sel && conv_sample < SMP_DIFF_BOT
    |=> st_reg.result == ACS_DIFF_MIN)
    else $error("negative overrange not saturated");

  a_done_flag_set: assert property ( // RQ4
    ce && capture |=> conversion_complete_flag)
    else $error("completion flag not set with new result");

  a_ref_decode: assert property ( // RQ5
    (st_reg.applied_ref == ACS_REF_INT) |-> ref_internal_on &&
    !ref_external_sel && !ref_supply_sel)
    else $error("internal reference not decoded");

  a_sel_deferred: assert property ( // RQ6
    ce && conv_busy && !conv_done ##1 ce && conv_busy && !conv_done
    |=> $stable(st_reg.applied_ch) && $stable(st_reg.applied_ref))
    else $error("selection changed during conversion");

  a_sel_applied: assert property ( // RQ6
    ce && conv_done |=> {st_reg.applied_ref, st_reg.applied_ch} ==
    $past(sel_fields))
    else $error("selection not applied at completion");

  a_left_adjust: assert property ( // RQ7
    st_reg.input_select[ACS_LADJ_BIT] |-> fmt_high == st_reg.result[9:2]
    && fmt_low[5:0] == 6'h00)
    else $error("left-adjusted bytes wrong");

  a_right_adjust: assert property ( // RQ12
    !st_reg.input_select[ACS_LADJ_BIT] |-> fmt_high[7:2] == 6'h00 &&
    fmt_high[1:0] == st_reg.result[9:8])
    else $error("right-adjusted bytes wrong");

  a_bandgap_pick: assert property ( // RQ8
    (st_reg.applied_ch == ACS_CH_BANDGAP) |-> bandgap_sel &&
    single_ended_sel && !ground_sel)
    else $error("bandgap code not decoded");

  a_gain_high: assert property ( // RQ9
    (st_reg.applied_ch[4:3] == 2'h1) |-> gain_sel ==
    (st_reg.applied_ch[1] ? ACS_GAIN_200X : ACS_GAIN_10X))
    else $error("gain pairs decoded wrongly");

  a_unity_gain: assert property ( // RQ10
    st_reg.applied_ch[4] && st_reg.applied_ch != ACS_CH_BANDGAP &&
    st_reg.applied_ch != ACS_CH_GROUND
    |-> gain_sel == ACS_GAIN_1X && !single_ended_sel)
    else $error("unity gain pairs decoded wrongly");

  a_sel_write: assert property ( // RQ11
    ce && commit && wr_strb0 && wr_addr == ACS_OFF_SELECT
    |=> st_reg.input_select == $past(wr_data))
    else $error("select register write lost");

  a_lock_hold: assert property ( // RQ13
    ce && st_reg.lock && conv_done |=> $stable(st_reg.result) &&
    st_reg.status[ACS_ST_DROP])
    else $error("locked result overwritten");

endmodule // acs_top

// >>> test/acs_conv_model.sv
// converter core stand-in: busy for a set time, then one done pulse
`timescale 1ns/1ns
module acs_conv_model #(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       go,
  input  wire logic [7:0]                 lat,
  input  wire logic signed [SAMPLE_W-1:0] samp,
  output logic                            conv_busy,
  output logic                            conv_done,
  output logic signed [SAMPLE_W-1:0]      conv_sample
);
  logic [7:0]                 cnt_reg;
  logic signed [SAMPLE_W-1:0] hold_reg;

  always_ff @(posedge aclk) begin
    conv_done <= 1'h0;
    // sample is only good in the done cycle, so it churns elsewhere
    conv_sample <= ~conv_sample;
    if (!aresetn) begin
      conv_busy <= 1'h0;
      cnt_reg <= 8'h00;
      conv_sample <= '0;
    end else if (go && !conv_busy) begin
      conv_busy <= 1'h1;
      cnt_reg <= lat;
      hold_reg <= samp;
    end else if (conv_busy) begin
      if (cnt_reg == 8'h00) begin
        conv_busy <= 1'h0;
        conv_done <= 1'h1;
        conv_sample <= hold_reg;
      end else begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule // acs_conv_model

// >>> test/acs_top_tb.sv
// testbench for the converter selection and result block
`timescale 1ns/1ns
module acs_top_tb import acs_pkg::*;;
  `define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    failures++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end

  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, go = 1'h0;
  logic s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_arvalid = 1'h0;
  logic s_axil_bready = 1'h1, s_axil_rready = 1'h1;
  logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00, lat = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata, rd;
  logic [3:0] s_axil_wstrb = 4'hf;
  logic [1:0] s_axil_bresp, s_axil_rresp, resp, neg_input_sel;
  logic signed [11:0] samp = 12'sh000, conv_sample;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready;
  logic s_axil_rvalid, conv_busy, conv_done, single_ended_sel, bandgap_sel;
  logic ground_sel, ref_external_sel, ref_supply_sel, ref_internal_on;
  logic ref_reserved_sel, conversion_complete_flag, irq;
  logic [2:0] pos_input_sel;
  acs_gain_e gain_sel;
  wire [3:0] ref_seen = {ref_external_sel, ref_supply_sel, ref_reserved_sel,
                         ref_internal_on};
  wire [7:0] pair_seen = {pos_input_sel, neg_input_sel, gain_sel};
  int failures = 0, cmp_count = 0, cyc = 0;

  acs_top #(.SAMPLE_W(12)) dut (.aclk, .aresetn, .ce, .s_axil_awaddr,
    .s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb,
    .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid,
    .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready,
    .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready,
    .conv_busy, .conv_done, .conv_sample, .single_ended_sel, .pos_input_sel,
    .neg_input_sel, .gain_sel, .bandgap_sel, .ground_sel, .ref_external_sel,
    .ref_supply_sel, .ref_internal_on, .ref_reserved_sel,
    .conversion_complete_flag, .irq);
  acs_conv_model #(.SAMPLE_W(12)) conv_model (.aclk, .aresetn, .go, .lat,
    .samp, .conv_busy, .conv_done, .conv_sample);

  initial forever #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end

  task automatic conclude;
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // ready is looked at mid-cycle: inputs only move at rising edges
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    bit aw, w, ah, wh;
    aw = 0;
    w = 0;
    s_axil_awaddr <= a;
    s_axil_wdata <= {24'h0, d};
    s_axil_awvalid <= 1'h1;
    s_axil_wvalid <= 1'h1;
    while (!(aw && w)) begin
      @(negedge aclk);
      ah = s_axil_awready && !aw;
      wh = s_axil_wready && !w;
      @(posedge aclk);
      if (ah) begin s_axil_awvalid <= 1'h0; aw = 1; end
      if (wh) begin s_axil_wvalid <= 1'h0; w = 1; end
    end
    do begin
      @(negedge aclk);
      ah = s_axil_bvalid;
      resp = s_axil_bresp;
      @(posedge aclk);
    end while (!ah);
  endtask

  task automatic axr(input logic [7:0] a);
    bit h;
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'h1;
    do begin @(negedge aclk); h = s_axil_arready; @(posedge aclk); end
    while (!h);
    s_axil_arvalid <= 1'h0;
    do begin
      @(negedge aclk);
      h = s_axil_rvalid;
      rd = s_axil_rdata;
      resp = s_axil_rresp;
      @(posedge aclk);
    end while (!h);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    axr(a);
    `CHK("register read", {ACS_RESP_OKAY, 24'h0, e}, {resp, rd})
  endtask

  task automatic res(input logic [7:0] lo, input logic [7:0] hi);
    rc(ACS_OFF_RES_LOW, lo);
    rc(ACS_OFF_RES_HIGH, hi);
  endtask

  task automatic kick(input logic signed [11:0] s, input logic [7:0] l);
    samp <= s;
    lat <= l;
    go <= 1'h1;
    @(posedge aclk);
    go <= 1'h0;
  endtask

  task automatic fin;
    do @(negedge aclk); while (!conv_done);
    @(posedge aclk);
  endtask

  task automatic dchk(input logic [4:0] c);
    logic se;
    logic [2:0] p;
    logic [1:0] n;
    acs_gain_e g;
    se = c < 5'h08 || c > 5'h1d;
    p = c[2:0];
    n = c[4:3] == 2'h3 ? 2'h2 : 2'h1;
    g = ACS_GAIN_1X;
    if (c[4:3] == 2'h1) begin
      p = {1'h0, c[2], c[0]};
      n = c[2] ? 2'h2 : 2'h0;
      g = c[1] ? ACS_GAIN_200X : ACS_GAIN_10X;
    end
    axw(ACS_OFF_SELECT, {3'h0, c});
    @(negedge aclk);
    `CHK("single", se, single_ended_sel)
    `CHK("bg gnd", {c == 5'h1e, c == 5'h1f}, {bandgap_sel, ground_sel})
    if (c < 5'h08) `CHK("input", c[2:0], pos_input_sel)
    if (!se) `CHK("pair", {p, n, g}, pair_seen)
    @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rc(ACS_OFF_SELECT, 8'h00);
    res(8'h00, 8'h00);
    axw(ACS_OFF_SELECT, 8'hff);
    rc(ACS_OFF_SELECT, 8'hff);
    for (int i = 0; i < 4; i++) begin
      axw(ACS_OFF_SELECT, {i[1:0], 6'h00});
      @(negedge aclk);
      `CHK("ref", 4'h8 >> i, ref_seen)
      @(posedge aclk);
    end
    for (int i = 0; i < 32; i++) dchk(i[4:0]);
    axw(ACS_OFF_SELECT, 8'h00);
    kick(12'sh2a5, 8'h00);
    fin();
    rc(ACS_OFF_STATUS, 8'h01);
    res(8'ha5, 8'h02);
    axw(ACS_OFF_SELECT, 8'h20);
    res(8'h40, 8'ha9);
    // slow conversion: selection waits, left adjust does not
    kick(-12'sh005, 8'h3c);
    axw(ACS_OFF_SELECT, 8'h1d);
    @(negedge aclk);
    `CHK("held", 5'h18, {conv_busy, single_ended_sel, pos_input_sel})
    @(posedge aclk);
    res(8'ha5, 8'h02);
    fin();
    res(8'h00, 8'h00);
    @(negedge aclk);
    `CHK("new sel", 4'h5, {single_ended_sel, pos_input_sel})
    @(posedge aclk);
    axw(ACS_OFF_SELECT, 8'h00);
    kick(12'sh5dc, 8'h00);
    fin();
    res(8'hff, 8'h03);
    axw(ACS_OFF_SELECT, 8'hed);
    kick(-12'sh190, 8'h02);
    fin();
    res(8'h00, 8'h9c);
    axw(ACS_OFF_SELECT, 8'hcd);
    res(8'h70, 8'h02);
    kick(12'sh258, 8'h00);
    fin();
    res(8'hff, 8'h01);
    kick(-12'sh258, 8'h00);
    fin();
    res(8'h00, 8'h02);
    kick(-12'sh001, 8'h00);
    fin();
    res(8'hff, 8'h03);
    axw(ACS_OFF_SELECT, 8'h00);
    kick(12'sh155, 8'h00);
    fin();
    rc(ACS_OFF_RES_LOW, 8'h55);
    kick(12'sh2aa, 8'h00);
    fin();
    rc(ACS_OFF_RES_HIGH, 8'h01);
    rc(ACS_OFF_STATUS, 8'h03);
    kick(12'sh2aa, 8'h00);
    fin();
    res(8'haa, 8'h02);
    axw(ACS_OFF_IRQ_CLEAR, 8'h03);
    rc(ACS_OFF_STATUS, 8'h00);
    axw(ACS_OFF_IRQ_EN, 8'h01);
    rc(ACS_OFF_IRQ_EN, 8'h01);
    kick(12'sh010, 8'h00);
    fin();
    @(negedge aclk);
    `CHK("irq set", 2'h3, {irq, conversion_complete_flag})
    @(posedge aclk);
    axw(ACS_OFF_IRQ_CLEAR, 8'h01);
    @(negedge aclk);
    `CHK("irq clr", 2'h0, {irq, conversion_complete_flag})
    @(posedge aclk);
    axw(ACS_OFF_IRQ_EN, 8'h00);
    kick(12'sh010, 8'h00);
    fin();
    @(negedge aclk);
    `CHK("irq mask", 2'h1, {irq, conversion_complete_flag})
    @(posedge aclk);
    // frozen block must refuse every request
    ce <= 1'h0;
    @(negedge aclk);
    `CHK("frozen", 3'h0, {s_axil_awready, s_axil_wready, s_axil_arready})
    @(posedge aclk);
    ce <= 1'h1;
    axw(8'h40, 8'h5a);
    `CHK("bad write", ACS_RESP_SLVERR, resp)
    axr(8'h40);
    `CHK("bad read", {ACS_RESP_SLVERR, 32'h0}, {resp, rd})
    conclude();
  end
endmodule // acs_top_tb
